// *** psp_defs.svh ***
`ifndef PSP_DEFS_SVH
`define PSP_DEFS_SVH

`define PSP_WORD_BITS      24
`define PSP_BYTE_BITS      8
`define PSP_SEL_R          2'h0
`define PSP_SEL_AB         2'h1
`define PSP_SEL_FUNC       2'h2
`define PSP_SEL_INIT       2'h3
`define PSP_CNT_RST_POS    2
`define PSP_MUX_LSB        4
`define PSP_MUX_MSB        6
`define PSP_MUX_LOCK       3'h1
`define PSP_WORD_ZERO      24'h00_0000
`define PSP_HALF_DIV       8'h04
`define PSP_BIAS_NS        1000
`define PSP_CLK_NS         100
`define PSP_BIAS_CYC       ((`PSP_BIAS_NS + `PSP_CLK_NS - 1) / `PSP_CLK_NS)

`endif

// *** psp_device.sv ***
`timescale 1ns/1ns
`include "psp_defs.svh"
module psp_device
  import psp_pkg::*;
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_ce,
  // link
  psp_if.device     link,
  // user side
  input  wire logic i_lock,
  output logic      o_powered_down,
  output logic      o_counter_reset,
  output logic      o_cp_tristate,
  output logic      o_init_pulse,
  output psp_word_t o_func_latch,
  output psp_word_t o_r_latch,
  output psp_word_t o_ab_latch
);
  typedef struct packed {
    logic [1:0] sck_sync;
    logic [1:0] dat_sync;
    logic [1:0] le_sync;
    logic [1:0] cpe_sync;
    logic [1:0] lock_sync;
    logic       sck_prev;
    logic       le_prev;
    psp_word_t  shift;
    psp_word_t  func;
    psp_word_t  r;
    psp_word_t  ab;
    logic       ab_pulse_armed;
    logic       pulse;
    logic       status;
  } psp_dev_state_t;

  psp_dev_state_t state_reg;
  psp_dev_state_t state_next;
  logic           sck_rise;
  logic           le_rise;

  always_comb begin
    state_next = state_reg;
    state_next.sck_sync  = {state_reg.sck_sync[0], link.serial_clk};
    state_next.dat_sync  = {state_reg.dat_sync[0], link.serial_data};
    state_next.le_sync   = {state_reg.le_sync[0], link.load_strobe};
    state_next.cpe_sync  = {state_reg.cpe_sync[0], link.chip_power_enable};
    state_next.lock_sync = {state_reg.lock_sync[0], i_lock};
    state_next.sck_prev  = state_reg.sck_sync[1];
    state_next.le_prev   = state_reg.le_sync[1];
    state_next.pulse     = 1'b0;
    sck_rise = state_reg.sck_sync[1] & ~state_reg.sck_prev;
    le_rise  = state_reg.le_sync[1] & ~state_reg.le_prev;
    // shifting ignores power-down
    if (sck_rise) begin
      state_next.shift = {state_reg.shift[`PSP_WORD_BITS-2:0], state_reg.dat_sync[1]};
    end
    if (le_rise) begin
      unique case (state_reg.shift[1:0])
        `PSP_SEL_R: state_next.r = state_reg.shift;
        `PSP_SEL_AB: begin
          state_next.ab = state_reg.shift;
          if (state_reg.ab_pulse_armed) begin
            state_next.pulse          = 1'b1;
            state_next.ab_pulse_armed = 1'b0;
          end
        end
        `PSP_SEL_FUNC: state_next.func = state_reg.shift;
        `PSP_SEL_INIT: begin
          state_next.func           = state_reg.shift;
          state_next.pulse          = 1'b1;
          state_next.ab_pulse_armed = 1'b1;
        end
      endcase
    end
    // mux field selects lock detect
    state_next.status = (state_reg.func[`PSP_MUX_MSB:`PSP_MUX_LSB] == `PSP_MUX_LOCK)
                        & state_reg.lock_sync[1];
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg         <= '0;
      // strobe idles high: start its detector high so no false load follows reset
      state_reg.le_sync <= 2'h3;
      state_reg.le_prev <= 1'b1;
    end else if (i_ce) begin
      state_reg <= state_next; // latches never cleared by enable
    end
  end

  assign o_powered_down  = ~state_reg.cpe_sync[1];
  assign o_counter_reset = state_reg.func[`PSP_CNT_RST_POS] | state_reg.pulse
                           | o_powered_down;
  assign o_cp_tristate   = o_counter_reset;
  assign o_init_pulse    = state_reg.pulse;
  assign o_func_latch    = state_reg.func;
  assign o_r_latch       = state_reg.r;
  assign o_ab_latch      = state_reg.ab;
  assign link.multiplexed_status_output = state_reg.status;
endmodule

// *** psp_host.sv ***
`timescale 1ns/1ns
`include "psp_defs.svh"
module psp_host
  import psp_pkg::*;
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_ce,
  // link
  psp_if.host       link,
  // user side
  input  wire logic i_start,
  input  psp_word_t i_word,
  input  wire logic i_enable,
  output logic      o_ready,
  output logic      o_done,
  output logic      o_bias_ok,
  output logic      o_lock
);
  typedef struct packed {
    psp_hstate_t fsm;
    psp_word_t   word;
    logic [4:0]  bits;
    logic [7:0]  div;
    logic        sck;
    logic        dat;
    logic        le;
    logic        cpe;
    logic [3:0]  bias;
    logic        done;
    logic [1:0]  lock_sync;
  } psp_host_state_t;

  psp_host_state_t state_reg;
  psp_host_state_t state_next;

  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    state_next.lock_sync = {state_reg.lock_sync[0], link.multiplexed_status_output};
    state_next.cpe = i_enable;
    if (!state_reg.cpe) begin
      state_next.bias = '0;
    end else if (state_reg.bias != 4'(`PSP_BIAS_CYC)) begin
      state_next.bias = state_reg.bias + 4'h1;
    end
    unique case (state_reg.fsm)
      PSP_IDLE: begin
        if (i_start) begin
          state_next.word = i_word;
          state_next.bits = 5'(`PSP_WORD_BITS);
          state_next.le   = 1'b0;
          state_next.div  = '0;
          state_next.fsm  = PSP_LOW;
        end
      end
      PSP_LOW: begin
        state_next.dat = state_reg.word[`PSP_WORD_BITS-1];
        state_next.div = state_reg.div + 8'h01;
        if (state_reg.div == `PSP_HALF_DIV) begin // 1 MHz, well under limit
          state_next.div = '0;
          state_next.sck = 1'b1;
          state_next.fsm = PSP_HIGH;
        end
      end
      PSP_HIGH: begin
        state_next.div = state_reg.div + 8'h01;
        if (state_reg.div == `PSP_HALF_DIV) begin
          state_next.div  = '0;
          state_next.sck  = 1'b0;
          state_next.word = {state_reg.word[`PSP_WORD_BITS-2:0], 1'b0};
          state_next.bits = state_reg.bits - 5'h01;
          state_next.fsm  = (state_reg.bits == 5'h01) ? PSP_GAP : PSP_LOW;
        end
      end
      PSP_GAP: begin
        state_next.le   = 1'b1; // after third byte
        state_next.done = 1'b1;
        state_next.fsm  = PSP_IDLE;
      end
      default: state_next.fsm = PSP_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg     <= '0;
      state_reg.le  <= 1'b1;
      state_reg.fsm <= PSP_IDLE;
    end else if (i_ce) begin
      state_reg <= state_next;
    end
  end

  // sequence of words (enable-pin or reset-bit startup, four first writes)
  // is the user's job
  assign o_ready   = (state_reg.fsm == PSP_IDLE);
  assign o_done    = state_reg.done;
  assign o_bias_ok = state_reg.cpe & (state_reg.bias == 4'(`PSP_BIAS_CYC));
  assign o_lock    = state_reg.lock_sync[1];
  assign link.serial_clk        = state_reg.sck;
  assign link.serial_data       = state_reg.dat;
  assign link.load_strobe       = state_reg.le;
  assign link.chip_power_enable = state_reg.cpe;
endmodule

// *** psp_if.sv ***
`timescale 1ns/1ns
interface psp_if;
  logic serial_clk;
  logic serial_data;
  logic load_strobe;
  logic chip_power_enable;
  logic multiplexed_status_output;
  modport device (input serial_clk, serial_data, load_strobe, chip_power_enable,
                  output multiplexed_status_output);
  modport host (output serial_clk, serial_data, load_strobe, chip_power_enable,
                input multiplexed_status_output);
endinterface

// *** psp_pkg.sv ***
package psp_pkg;
  `include "psp_defs.svh"
  typedef logic [`PSP_WORD_BITS-1:0] psp_word_t;
  typedef enum logic [2:0] {PSP_IDLE, PSP_LOW, PSP_HIGH, PSP_GAP, PSP_WAIT} psp_hstate_t;
endpackage

// *** psp_properties.sv ***
`timescale 1ns/1ns
module psp_properties (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // link
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic load_strobe,
  input wire logic chip_power_enable,
  input wire logic multiplexed_status_output
);
  logic [4:0] rise_cnt_reg;
  logic       sck_reg;

  // counts serial clock rises inside one frame
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rise_cnt_reg <= 5'h0;
      sck_reg      <= 1'b0;
    end else begin
      sck_reg <= serial_clk;
      if (load_strobe) begin
        rise_cnt_reg <= 5'h0;
      end else if (serial_clk && !sck_reg) begin
        rise_cnt_reg <= rise_cnt_reg + 5'h1;
      end
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  a_sck_idle_low: assert property (load_strobe |-> !serial_clk)
    else $error("serial clock high outside a frame");
  a_data_stable_edge: assert property ($rose(serial_clk) |-> $stable(serial_data))
    else $error("data moved at the sampling edge");
  a_sck_high_width: assert property ($rose(serial_clk) |-> serial_clk[*5] ##1 !serial_clk)
    else $error("serial clock high phase wrong");
  a_sck_low_width: assert property ($fell(serial_clk) |-> !serial_clk[*3])
    else $error("serial clock low phase too short");
  a_frame_start: assert property ($fell(load_strobe) |-> ##[1:12] $rose(serial_clk))
    else $error("no first bit after strobe fell");
  a_word_bits: assert property ($rose(load_strobe) |-> rise_cnt_reg == 5'h18)
    else $error("frame did not carry 24 bits");
  a_sck_in_frame: assert property ($rose(serial_clk) |-> !load_strobe)
    else $error("serial clock rose with strobe high");
  a_strobe_hold: assert property ($rose(load_strobe) |-> load_strobe[*2])
    else $error("strobe high too briefly");
endmodule

// *** psp_tb_top.sv ***
`timescale 1ns/1ns
module psp_tb_top;
  import psp_pkg::*;
  logic      i_clk, i_resetn, start, enable, lock;
  logic      ready, done, bias_ok, lock_seen, pdown, crst, cpts, ipulse;
  psp_word_t word, func_l, r_l, ab_l;
  int        error_cnt, comparisons, pulses;

  psp_if lnk ();
  psp_host i_psp_host (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(1'b1), .link(lnk),
    .i_start(start), .i_word(word), .i_enable(enable), .o_ready(ready), .o_done(done),
    .o_bias_ok(bias_ok), .o_lock(lock_seen));
  psp_device i_psp_device (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(1'b1), .link(lnk),
    .i_lock(lock), .o_powered_down(pdown), .o_counter_reset(crst), .o_cp_tristate(cpts),
    .o_init_pulse(ipulse), .o_func_latch(func_l), .o_r_latch(r_l), .o_ab_latch(ab_l));
  psp_properties i_psp_properties (.i_clk(i_clk), .i_resetn(i_resetn),
    .serial_clk(lnk.serial_clk), .serial_data(lnk.serial_data),
    .load_strobe(lnk.load_strobe), .chip_power_enable(lnk.chip_power_enable),
    .multiplexed_status_output(lnk.multiplexed_status_output));

  always @(posedge i_clk) if (ipulse === 1'b1) pulses++;

  task summarize;
    if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task chk(input string what, input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task wr(input psp_word_t w);
    cyc(1);
    chk("ready", ready, 1);
    start = 1'b1;
    word = w;
    cyc(1);
    start = 1'b0;
    repeat (300) begin
      cyc(1);
      if (done === 1'b1) break;
    end
    chk("done", done, 1);
    cyc(8);
  endtask

  task t_ce_method;
    chk("pdown", pdown, 1);
    wr(24'h00_0002);
    wr(24'h12_3450);
    wr(24'h0A_BC01);
    chk("pdown", pdown, 1);
    chk("func", func_l, 24'h00_0002);
    chk("r", r_l, 24'h12_3450);
    chk("ab", ab_l, 24'h0A_BC01);
    enable = 1'b1;
    cyc(4);
    chk("bias", bias_ok, 0);
    cyc(10);
    chk("bias", bias_ok, 1);
    chk("pdown", pdown, 0);
    enable = 1'b0;
    cyc(5);
    chk("pdown", pdown, 1);
    enable = 1'b1;
    cyc(15);
    chk("r", r_l, 24'h12_3450);
  endtask

  task t_reset_method;
    wr(24'h00_0006);
    chk("crst", crst, 1);
    chk("cpts", cpts, 1);
    chk("pdown", pdown, 0);
    wr(24'h00_0000);
    wr(24'h0A_BC01);
    wr(24'h00_0002);
    chk("crst", crst, 0);
    chk("cpts", cpts, 0);
  endtask

  task t_init;
    wr(24'h00_0013);
    chk("pulses", pulses, 1);
    chk("func", func_l, 24'h00_0013);
    wr(24'h0A_BC01);
    chk("pulses", pulses, 2);
    wr(24'h0A_BC05);
    chk("pulses", pulses, 2);
    chk("ab", ab_l, 24'h0A_BC05);
  endtask

  task t_lock;
    lock = 1'b1;
    cyc(6);
    chk("mux", lnk.multiplexed_status_output, 1);
    chk("lock", lock_seen, 1);
    lock = 1'b0;
    cyc(6);
    chk("lock", lock_seen, 0);
  endtask

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  initial begin
    #1_000_000;
    error_cnt++;
    summarize();
  end

  initial begin
    i_resetn = 1'b0;
    start = 1'b0;
    word = 24'h00_0000;
    enable = 1'b0;
    lock = 1'b0;
    cyc(4);
    i_resetn = 1'b1;
    t_ce_method();
    t_reset_method();
    t_init();
    t_lock();
    summarize();
  end
endmodule
